// ==== rtl/bioc_params.svh ====
// constants of the buffered channel control block
`ifndef BIOC_PARAMS_SVH
`define BIOC_PARAMS_SVH
`define BIOC_WORD_W 24
`define BIOC_ADDR_W 16
`define BIOC_DEV_W 6
`define BIOC_NCH 4
// core block of control words: count at base+2*ch, address at base+2*ch+1
`define BIOC_CW_BASE 16'h0100
// fixed monitor interrupt locations: base+ch
`define BIOC_IRQ_BASE 16'h0040
// factory assignment of the four fast registers (bit = channel, 0-3 in, 4-7 out)
`define BIOC_FAST_CNT_MAP 8'h11
`define BIOC_FAST_ADR_MAP 8'h11
`define BIOC_DEV_RST 6'h00
`define BIOC_WORD_RST 24'h000000
`define BIOC_ADDR_RST 16'h0000
`endif

// ==== rtl/bioc_pkg.sv ====
// types shared by the buffered channel control block
package bioc_pkg;
  `include "bioc_params.svh"
  typedef logic [`BIOC_WORD_W-1:0] bioc_word_t;
  typedef logic [`BIOC_ADDR_W-1:0] bioc_addr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CNT_RD = 3'h1,
    ST_CNT_WR = 3'h3,
    ST_ADR_RD = 3'h2,
    ST_ADR_WR = 3'h6,
    ST_DAT = 3'h7
  } bioc_state_t;
  typedef struct packed {
    logic req;
    logic we;
    bioc_addr_t addr;
    bioc_word_t wdata;
  } bioc_mem_t;
  typedef struct packed {
    logic [1:0] chan;
    bioc_word_t data;
  } bioc_oword_t;
endpackage : bioc_pkg

// ==== rtl/bioc_skid.sv ====
// two-entry buffer with valid/ready on both sides, all outputs registered
`timescale 1ns/100ps
module bioc_skid #(
  parameter int W = 26
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  typedef struct packed {
    logic mv;
    logic [W-1:0] md;
    logic sv;
    logic [W-1:0] sd;
  } bioc_skid_st_t;

  bioc_skid_st_t s_r;
  bioc_skid_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!s_r.mv || out_ready_i) begin
      // head is free or leaving: spare drains first to keep order
      if (s_r.sv) begin
        s_nxt.mv = 1'b1;
        s_nxt.md = s_r.sd;
        s_nxt.sv = 1'b0;
      end else begin
        s_nxt.mv = in_valid_i;
        s_nxt.md = in_data_i;
      end
    end else if (in_valid_i && !s_r.sv) begin
      s_nxt.sv = 1'b1;
      s_nxt.sd = in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_o = !s_r.sv;
  assign out_valid_o = s_r.mv;
  assign out_data_o = s_r.md;
endmodule : bioc_skid

// ==== rtl/bioc_chan_ctrl.sv ====
// buffered input/output channel control: cycle stealing word transfers
`timescale 1ns/100ps
`include "bioc_params.svh"
module bioc_chan_ctrl #(
  parameter logic [2*`BIOC_NCH-1:0] FAST_CNT_MAP = `BIOC_FAST_CNT_MAP,
  parameter logic [2*`BIOC_NCH-1:0] FAST_ADR_MAP = `BIOC_FAST_ADR_MAP,
  parameter bioc_pkg::bioc_addr_t CW_BASE = `BIOC_CW_BASE,
  parameter bioc_pkg::bioc_addr_t IRQ_BASE = `BIOC_IRQ_BASE
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // peripheral side
  input wire logic [`BIOC_NCH-1:0] IN_REQ_I,
  input wire logic [`BIOC_NCH-1:0][`BIOC_WORD_W-1:0] IN_DATA_I,
  output logic [`BIOC_NCH-1:0] IN_ACK_O,
  input wire logic [`BIOC_NCH-1:0] OUT_REQ_I,
  output logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  output bioc_pkg::bioc_oword_t OUT_WORD_O,
  output logic [`BIOC_DEV_W-1:0] DEV_ADDR_O,
  // program side
  input wire logic ACT_I,
  input wire logic [2:0] ACT_CHAN_I,
  input wire logic EF_I,
  input wire logic [`BIOC_DEV_W-1:0] EF_DEV_I,
  input wire logic FW_I,
  input wire logic [2:0] FW_CHAN_I,
  input wire logic FW_SEL_ADR_I,
  input wire bioc_pkg::bioc_word_t FW_DATA_I,
  input wire logic LOCKOUT_I,
  input wire logic IRQ_TAKE_I,
  output logic MON_IRQ_O,
  output bioc_pkg::bioc_addr_t MON_VEC_O,
  output logic HOLD_O,
  output logic [2*`BIOC_NCH-1:0] ACTIVE_O,
  // core memory side
  output bioc_pkg::bioc_mem_t MEM_O,
  input wire bioc_pkg::bioc_word_t MEM_RDATA_I,
  input wire logic MEM_ACK_I
);
  // channel index: inputs 0-3, outputs 4-7
  localparam int NCH = `BIOC_NCH;
  localparam int NALL = 2 * `BIOC_NCH;

  typedef struct packed {
    bioc_pkg::bioc_state_t st;
    logic [2:0] cur;
    logic zero;
    bioc_pkg::bioc_addr_t daddr;
    bioc_pkg::bioc_mem_t mem;
    logic hold;
    logic [NALL-1:0] active;
    logic [NALL-1:0] pend;
    logic [NALL-1:0] irq_pend;
    logic irq;
    logic [2:0] irq_ch;
    bioc_pkg::bioc_addr_t vec;
    logic [NCH-1:0] in_ack;
    logic [NALL-1:0] req_m;
    logic [NALL-1:0] req_s;
    logic [NALL-1:0] req_p;
    logic [NCH-1:0][`BIOC_WORD_W-1:0] din_m;
    logic [NCH-1:0][`BIOC_WORD_W-1:0] din_s;
    logic rdy_m;
    logic rdy_s;
    logic push;
    bioc_pkg::bioc_oword_t push_w;
    logic [`BIOC_DEV_W-1:0] dev;
    logic [NALL-1:0][`BIOC_WORD_W-1:0] fcnt;
    logic [NALL-1:0][`BIOC_WORD_W-1:0] fadr;
  } bioc_core_st_t;

  bioc_core_st_t s_r;
  bioc_core_st_t s_nxt;
  // room in the output buffer for one more word
  logic buf_rdy;

  // one memory access, held until acknowledged
  function automatic bioc_pkg::bioc_mem_t mk_acc(input logic we,
                                                 input bioc_pkg::bioc_addr_t addr,
                                                 input bioc_pkg::bioc_word_t wdata);
    bioc_pkg::bioc_mem_t m;
    m.req = 1'b1;
    m.we = we;
    m.addr = addr;
    m.wdata = wdata;
    return m;
  endfunction : mk_acc

  // core location of a control word: word 0 count, word 1 address
  function automatic bioc_pkg::bioc_addr_t cw_addr(input logic [2:0] ch,
                                                   input logic word);
    return CW_BASE + bioc_pkg::bioc_addr_t'({ch, word});
  endfunction : cw_addr

  // data cycle: input writes the peripheral word, output reads memory
  function automatic bioc_pkg::bioc_mem_t dat_acc(input logic [2:0] ch,
                                                  input bioc_pkg::bioc_addr_t addr,
                                                  input bioc_pkg::bioc_word_t din);
    return mk_acc(!ch[2], addr, din);
  endfunction : dat_acc

  always_comb begin
    logic [NALL-1:0] rise;
    logic [NALL-1:0] cand;
    logic [NALL-1:0] pclr;
    logic [NALL-1:0] arm;
    logic [NALL-1:0] iclr;
    logic [2:0] pick;
    logic found;
    logic [2:0] ich;
    logic ifound;
    bioc_pkg::bioc_word_t v;
    rise = '0;
    cand = '0;
    pclr = '0;
    arm = '0;
    iclr = '0;
    pick = 3'h0;
    found = 1'b0;
    ich = 3'h0;
    ifound = 1'b0;
    v = `BIOC_WORD_RST;
    s_nxt = s_r;

    // pin synchronisers; the first stage is never looked at
    s_nxt.req_m = {OUT_REQ_I, IN_REQ_I};
    s_nxt.req_s = s_r.req_m;
    s_nxt.req_p = s_r.req_s;
    s_nxt.din_m = IN_DATA_I;
    s_nxt.din_s = s_r.din_m;
    s_nxt.rdy_m = OUT_READY_I;
    s_nxt.rdy_s = s_r.rdy_m;
    s_nxt.push = 1'b0;

    // a new request is recorded on its rising edge while active
    rise = s_r.req_s & ~s_r.req_p & s_r.active;
    // output channels wait for buffer room, so a stalled receiver loses nothing
    cand = s_r.pend & s_r.active
         & {{NCH{buf_rdy & !s_r.push}}, {NCH{1'b1}}};
    for (int i = 0; i < NALL; i++) begin
      if (cand[i] && !found) begin
        found = 1'b1;
        pick = 3'(i);
      end
    end

    // input ack stays up until the peripheral drops its request
    s_nxt.in_ack = s_r.in_ack & s_r.req_s[NCH-1:0];

    // program loads fast control words only while the channel is idle
    // a load aimed at an active channel is dropped without any sign
    if (FW_I && !s_r.active[FW_CHAN_I]) begin
      if (FW_SEL_ADR_I) begin
        s_nxt.fadr[FW_CHAN_I] = FW_DATA_I;
      end else begin
        s_nxt.fcnt[FW_CHAN_I] = FW_DATA_I;
      end
    end
    if (EF_I) begin
      s_nxt.dev = EF_DEV_I;
    end

    unique case (s_r.st)
      bioc_pkg::ST_IDLE: begin
        if (found) begin
          s_nxt.cur = pick;
          s_nxt.hold = 1'b1;
          pclr[pick] = 1'b1;
          if (FAST_CNT_MAP[pick]) begin
            v = s_r.fcnt[pick] - `BIOC_WORD_W'(1);
            s_nxt.fcnt[pick] = v;
            s_nxt.zero = (v == `BIOC_WORD_RST);
            if (FAST_ADR_MAP[pick]) begin
              s_nxt.daddr = s_r.fadr[pick][`BIOC_ADDR_W-1:0];
              s_nxt.fadr[pick] = s_r.fadr[pick] + `BIOC_WORD_W'(1);
              s_nxt.mem = dat_acc(pick, s_r.fadr[pick][`BIOC_ADDR_W-1:0],
                                  s_r.din_s[pick[1:0]]);
              s_nxt.st = bioc_pkg::ST_DAT;
            end else begin
              s_nxt.mem = mk_acc(1'b0, cw_addr(pick, 1'b1), `BIOC_WORD_RST);
              s_nxt.st = bioc_pkg::ST_ADR_RD;
            end
          end else begin
            s_nxt.mem = mk_acc(1'b0, cw_addr(pick, 1'b0), `BIOC_WORD_RST);
            s_nxt.st = bioc_pkg::ST_CNT_RD;
          end
        end
      end
      bioc_pkg::ST_CNT_RD: begin
        if (MEM_ACK_I) begin
          // modify between read and restore of the same core cycle
          // a count read as zero wraps round; no special case
          v = MEM_RDATA_I - `BIOC_WORD_W'(1);
          s_nxt.zero = (v == `BIOC_WORD_RST);
          s_nxt.mem = mk_acc(1'b1, s_r.mem.addr, v);
          s_nxt.st = bioc_pkg::ST_CNT_WR;
        end
      end
      bioc_pkg::ST_CNT_WR: begin
        if (MEM_ACK_I) begin
          if (FAST_ADR_MAP[s_r.cur]) begin
            s_nxt.daddr = s_r.fadr[s_r.cur][`BIOC_ADDR_W-1:0];
            s_nxt.fadr[s_r.cur] = s_r.fadr[s_r.cur] + `BIOC_WORD_W'(1);
            s_nxt.mem = dat_acc(s_r.cur, s_r.fadr[s_r.cur][`BIOC_ADDR_W-1:0],
                                s_r.din_s[s_r.cur[1:0]]);
            s_nxt.st = bioc_pkg::ST_DAT;
          end else begin
            s_nxt.mem = mk_acc(1'b0, cw_addr(s_r.cur, 1'b1), `BIOC_WORD_RST);
            s_nxt.st = bioc_pkg::ST_ADR_RD;
          end
        end
      end
      bioc_pkg::ST_ADR_RD: begin
        if (MEM_ACK_I) begin
          // full-width increment; only the low bits address memory
          s_nxt.daddr = MEM_RDATA_I[`BIOC_ADDR_W-1:0];
          s_nxt.mem = mk_acc(1'b1, s_r.mem.addr,
                             MEM_RDATA_I + `BIOC_WORD_W'(1));
          s_nxt.st = bioc_pkg::ST_ADR_WR;
        end
      end
      bioc_pkg::ST_ADR_WR: begin
        if (MEM_ACK_I) begin
          // saved pre-increment address drives the data cycle
          s_nxt.mem = dat_acc(s_r.cur, s_r.daddr, s_r.din_s[s_r.cur[1:0]]);
          s_nxt.st = bioc_pkg::ST_DAT;
        end
      end
      bioc_pkg::ST_DAT: begin
        if (MEM_ACK_I) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.hold = 1'b0;
          s_nxt.st = bioc_pkg::ST_IDLE;
          // output word reaches the buffer one cycle later
          if (s_r.cur[2]) begin
            s_nxt.push = 1'b1;
            s_nxt.push_w.chan = s_r.cur[1:0];
            s_nxt.push_w.data = MEM_RDATA_I;
          end else begin
            s_nxt.in_ack[s_r.cur[1:0]] = 1'b1;
          end
          // the word still moves; only then does the channel stop
          if (s_r.zero) begin
            s_nxt.active[s_r.cur] = 1'b0;
            arm[s_r.cur] = 1'b1;
          end
        end
      end
      // unused state codes fall back to idle
      default: begin
        s_nxt.st = bioc_pkg::ST_IDLE;
        s_nxt.mem.req = 1'b0;
        s_nxt.hold = 1'b0;
      end
    endcase

    // activate after the sequencer so a fresh activation is never lost
    if (ACT_I) begin
      s_nxt.active[ACT_CHAN_I] = 1'b1;
    end
    s_nxt.pend = (s_r.pend & ~pclr) | rise;

    // monitor interrupt: lowest pending channel, held off by lockout
    for (int i = 0; i < NALL; i++) begin
      if (s_r.irq_pend[i] && !ifound) begin
        ifound = 1'b1;
        ich = 3'(i);
      end
    end
    // a shown interrupt drops under lockout but stays pending
    if (s_r.irq && IRQ_TAKE_I) begin
      s_nxt.irq = 1'b0;
      iclr[s_r.irq_ch] = 1'b1;
    end else if (LOCKOUT_I) begin
      s_nxt.irq = 1'b0;
    end else if (!s_r.irq && ifound) begin
      s_nxt.irq = 1'b1;
      s_nxt.irq_ch = ich;
      s_nxt.vec = IRQ_BASE + bioc_pkg::bioc_addr_t'(ich);
    end
    // a new arm wins over a clear in the same cycle
    s_nxt.irq_pend = (s_r.irq_pend & ~iclr) | arm;
  end


  // one register for the whole state; reset clears every field
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // spare entry absorbs the late, synchronised ready
  bioc_skid #(
    .W($bits(bioc_pkg::bioc_oword_t))
  ) u_obuf (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .in_valid_i(s_r.push),
    .in_ready_o(buf_rdy),
    .in_data_i(s_r.push_w),
    .out_valid_o(OUT_VALID_O),
    .out_ready_i(s_r.rdy_s),
    .out_data_o(OUT_WORD_O)
  );


  // every output straight from a register
  assign IN_ACK_O = s_r.in_ack;
  assign DEV_ADDR_O = s_r.dev;
  assign MON_IRQ_O = s_r.irq;
  assign MON_VEC_O = s_r.vec;
  assign HOLD_O = s_r.hold;
  assign ACTIVE_O = s_r.active;
  assign MEM_O = s_r.mem;
endmodule : bioc_chan_ctrl

// ==== verif/bioc_chan_ctrl_props.sv ====
// port assertions for the buffered channel control
`timescale 1ns/100ps
`include "bioc_params.svh"
module bioc_chan_ctrl_props #(
  parameter bioc_pkg::bioc_addr_t IRQ_BASE = `BIOC_IRQ_BASE
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  input wire bioc_pkg::bioc_oword_t OUT_WORD_O,
  input wire logic [`BIOC_DEV_W-1:0] DEV_ADDR_O,
  input wire logic ACT_I,
  input wire logic [2:0] ACT_CHAN_I,
  input wire logic EF_I,
  input wire logic [`BIOC_DEV_W-1:0] EF_DEV_I,
  input wire logic LOCKOUT_I,
  input wire logic IRQ_TAKE_I,
  input wire logic MON_IRQ_O,
  input wire bioc_pkg::bioc_addr_t MON_VEC_O,
  input wire logic HOLD_O,
  input wire logic [2*`BIOC_NCH-1:0] ACTIVE_O,
  input wire bioc_pkg::bioc_mem_t MEM_O,
  input wire logic MEM_ACK_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_mem_hold;
    MEM_O.req && !MEM_ACK_I |=> $stable(MEM_O);
  endproperty
  property p_steal;
    MEM_O.req |-> HOLD_O;
  endproperty
  property p_lock;
    LOCKOUT_I |=> !MON_IRQ_O;
  endproperty
  // vector names a channel already switched off
  property p_vec;
    MON_IRQ_O |-> MON_VEC_O[15:3] == IRQ_BASE[15:3] && !ACTIVE_O[MON_VEC_O[2:0]];
  endproperty
  property p_take;
    MON_IRQ_O && IRQ_TAKE_I |=> !MON_IRQ_O;
  endproperty
  property p_dev;
    EF_I |=> DEV_ADDR_O == $past(EF_DEV_I);
  endproperty
  property p_act;
    ACT_I |=> ACTIVE_O[$past(ACT_CHAN_I)];
  endproperty
  // ready passes two sync stages, so only a long stall must freeze the head
  property p_out_hold;
    !OUT_READY_I [*4] ##0 OUT_VALID_O |=> OUT_VALID_O && $stable(OUT_WORD_O);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed before ack");
  a_steal: assert property (p_steal)
    else $error("memory access without program hold");
  a_lock: assert property (p_lock)
    else $error("interrupt shown under lockout");
  a_vec: assert property (p_vec)
    else $error("bad interrupt vector");
  a_take: assert property (p_take)
    else $error("interrupt not cleared by take");
  a_dev: assert property (p_dev)
    else $error("device select not loaded");
  a_act: assert property (p_act)
    else $error("channel not activated");
  a_out_hold: assert property (p_out_hold)
    else $error("output word dropped during stall");
  c_irq: cover property ($rose(MON_IRQ_O));
  c_stall: cover property (OUT_VALID_O && !OUT_READY_I);
  c_steal: cover property ($rose(HOLD_O));
endmodule : bioc_chan_ctrl_props

bind bioc_chan_ctrl bioc_chan_ctrl_props #(.IRQ_BASE(IRQ_BASE)) u_props (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I),
  .OUT_WORD_O(OUT_WORD_O), .DEV_ADDR_O(DEV_ADDR_O), .ACT_I(ACT_I), .ACT_CHAN_I(ACT_CHAN_I),
  .EF_I(EF_I), .EF_DEV_I(EF_DEV_I), .LOCKOUT_I(LOCKOUT_I), .IRQ_TAKE_I(IRQ_TAKE_I),
  .MON_IRQ_O(MON_IRQ_O), .MON_VEC_O(MON_VEC_O), .HOLD_O(HOLD_O), .ACTIVE_O(ACTIVE_O),
  .MEM_O(MEM_O), .MEM_ACK_I(MEM_ACK_I)
);

// ==== verif/bioc_periph.sv ====
// peripheral model: four-phase input words, output requests, stalling receiver
`timescale 1ns/100ps
module bioc_periph (
  input wire logic clk_i,
  input wire logic [1:0] stall_i,
  input wire logic [3:0] in_ack_i,
  output logic [3:0] in_req_o,
  output logic [3:0][23:0] in_data_o,
  output logic [3:0] out_req_o,
  output logic out_ready_o
);
  logic [2:0] pat_r = 3'h0;
  initial begin
    in_req_o = 4'h0;
    in_data_o = '0;
    out_req_o = 4'h0;
    out_ready_o = 1'b0;
  end
  // mode 1 drops ready five cycles in eight, mode 2 holds it low
  always @(posedge clk_i) begin
    pat_r <= pat_r + 3'h1;
    out_ready_o <= stall_i == 2'h0 || (stall_i == 2'h1 && pat_r > 3'h4);
  end
  task automatic send_in(input int ch, input logic [23:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    in_data_o[ch] <= d;
    in_req_o[ch] <= 1'b1;
    while (in_ack_i[ch] !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    in_req_o[ch] <= 1'b0;
    while (in_ack_i[ch] !== 1'b0 && n < 800) begin
      @(posedge clk_i);
      n++;
    end
    // released data lines must not keep the last word
    in_data_o[ch] <= ~d;
    ok = n < 400;
  endtask : send_in
  task automatic pulse_out(input int ch);
    @(posedge clk_i);
    out_req_o[ch] <= 1'b1;
    repeat (4) @(posedge clk_i);
    out_req_o[ch] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse_out
endmodule : bioc_periph

// ==== verif/tb_buffered_io_channel_control.sv ====
// bench: core memory model, peripheral partner, expected words and interrupts
`timescale 1ns/100ps
`include "bioc_params.svh"
module tb_buffered_io_channel_control;
  logic CLK_I = 1'b0;
  logic RESETN_I = 1'b0;
  logic [3:0] IN_REQ_I, IN_ACK_O, OUT_REQ_I;
  logic [3:0][23:0] IN_DATA_I;
  logic OUT_VALID_O, OUT_READY_I, ACT_I, EF_I, FW_I, FW_SEL_ADR_I, LOCKOUT_I, IRQ_TAKE_I;
  logic MON_IRQ_O, HOLD_O, MEM_ACK_I, go;
  logic [5:0] DEV_ADDR_O, EF_DEV_I;
  logic [2:0] ACT_CHAN_I, FW_CHAN_I;
  logic [7:0] ACTIVE_O;
  logic [1:0] stall, slow, dly;
  bioc_pkg::bioc_oword_t OUT_WORD_O;
  bioc_pkg::bioc_word_t FW_DATA_I, MEM_RDATA_I, last;
  bioc_pkg::bioc_word_t mem [0:65535];
  bioc_pkg::bioc_word_t exp_d [8][4];
  bioc_pkg::bioc_addr_t MON_VEC_O;
  bioc_pkg::bioc_mem_t MEM_O;
  int fails = 0;
  int cmp_count = 0;
  int nacc = 0;
  always #2 CLK_I = ~CLK_I;
  bioc_chan_ctrl DUT (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .IN_REQ_I(IN_REQ_I),
    .IN_DATA_I(IN_DATA_I), .IN_ACK_O(IN_ACK_O), .OUT_REQ_I(OUT_REQ_I),
    .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I), .OUT_WORD_O(OUT_WORD_O),
    .DEV_ADDR_O(DEV_ADDR_O), .ACT_I(ACT_I), .ACT_CHAN_I(ACT_CHAN_I), .EF_I(EF_I),
    .EF_DEV_I(EF_DEV_I), .FW_I(FW_I), .FW_CHAN_I(FW_CHAN_I), .FW_SEL_ADR_I(FW_SEL_ADR_I),
    .FW_DATA_I(FW_DATA_I), .LOCKOUT_I(LOCKOUT_I), .IRQ_TAKE_I(IRQ_TAKE_I),
    .MON_IRQ_O(MON_IRQ_O), .MON_VEC_O(MON_VEC_O), .HOLD_O(HOLD_O), .ACTIVE_O(ACTIVE_O),
    .MEM_O(MEM_O), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I));
  bioc_periph P (.clk_i(CLK_I), .stall_i(stall), .in_ack_i(IN_ACK_O), .in_req_o(IN_REQ_I),
    .in_data_o(IN_DATA_I), .out_req_o(OUT_REQ_I), .out_ready_o(OUT_READY_I));
  // core memory: ack after a random wait, read data garbled between acks
  assign go = RESETN_I && MEM_O.req && !MEM_ACK_I && dly == 2'h0;
  always @(posedge CLK_I) begin
    MEM_ACK_I <= go;
    MEM_RDATA_I <= go ? mem[MEM_O.addr] : ~MEM_RDATA_I;
    if (go && MEM_O.we) mem[MEM_O.addr] <= MEM_O.wdata;
    if (MEM_O.req && MEM_ACK_I) nacc++;
    dly <= (go || MEM_ACK_I || !MEM_O.req) ? slow : dly - 2'h1;
  end
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic hang();
    fails++;
    $display("[ERR] %0t wait limit", $time);
    end_of_test();
  endtask : hang
  task automatic guard(inout int n);
    @(posedge CLK_I);
    n++;
    if (n > 500) hang();
  endtask : guard
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // kind: 0 activate, 1 device select, 2 fast count, 3 fast address, 4 take
  task automatic pulse(input int kind, input int ch, input logic [23:0] d);
    @(posedge CLK_I);
    ACT_I <= kind == 0;
    EF_I <= kind == 1;
    FW_I <= kind == 2 || kind == 3;
    IRQ_TAKE_I <= kind == 4;
    ACT_CHAN_I <= 3'(ch);
    FW_CHAN_I <= 3'(ch);
    FW_SEL_ADR_I <= kind == 3;
    FW_DATA_I <= d;
    EF_DEV_I <= d[5:0];
    @(posedge CLK_I);
    {ACT_I, EF_I, FW_I, IRQ_TAKE_I} <= 4'h0;
  endtask : pulse
  task automatic setup(input int ch, input int n);
    int a;
    a = 16'h0200 + 16 * ch;
    for (int k = 0; k < n; k++) begin
      exp_d[ch][k] = $urandom;
      mem[a + k] = ch < 4 ? ~exp_d[ch][k] : exp_d[ch][k];
    end
    if ((`BIOC_FAST_CNT_MAP >> ch) & 1) pulse(2, ch, 24'(n));
    else mem[`BIOC_CW_BASE + 2 * ch] = 24'(n);
    if ((`BIOC_FAST_ADR_MAP >> ch) & 1) pulse(3, ch, 24'(a));
    else mem[`BIOC_CW_BASE + 2 * ch + 1] = 24'(a);
    pulse(0, ch, 24'h000000);
    @(posedge CLK_I);
    chk(ACTIVE_O[ch], 1, "channel not active");
  endtask : setup
  task automatic xfer(input int ch, input int k, input bit count_acc);
    int n;
    bit ok;
    n = 0;
    nacc = 0;
    slow <= 2'($urandom);
    if (ch < 4) begin
      P.send_in(ch, exp_d[ch][k], ok);
      if (!ok) hang();
      chk(mem[16'h0200 + 16 * ch + k], exp_d[ch][k], "input word");
    end else begin
      fork
        P.pulse_out(ch - 4);
      join_none
      while (OUT_VALID_O !== 1'b1) guard(n);
      chk(OUT_WORD_O, {2'(ch - 4), exp_d[ch][k]}, "output word");
      while (OUT_VALID_O !== 1'b0) guard(n);
      wait fork;
    end
    n = ((`BIOC_FAST_CNT_MAP >> ch) & 1) + ((`BIOC_FAST_ADR_MAP >> ch) & 1);
    if (count_acc) chk(nacc, 5 - 2 * n, "memory accesses");
    // a parallel transfer on another channel may still hold the program
    if (count_acc) chk(HOLD_O, 0, "program still held");
  endtask : xfer
  task automatic finish(input int ch, input int n, input bit lock);
    int k;
    k = 0;
    if (!((`BIOC_FAST_CNT_MAP >> ch) & 1))
      chk(mem[`BIOC_CW_BASE + 2 * ch], 0, "count word");
    if (!((`BIOC_FAST_ADR_MAP >> ch) & 1))
      chk(mem[`BIOC_CW_BASE + 2 * ch + 1], 16'h0200 + 16 * ch + n, "address word");
    if (lock) begin
      repeat (20) begin
        @(posedge CLK_I);
        chk(MON_IRQ_O, 0, "interrupt under lockout");
      end
      LOCKOUT_I <= 1'b0;
    end
    while (MON_IRQ_O !== 1'b1) guard(k);
    chk(ACTIVE_O[ch], 0, "channel still active");
    chk(MON_VEC_O, `BIOC_IRQ_BASE + ch, "vector");
    pulse(4, ch, 24'h000000);
    @(posedge CLK_I);
    chk(MON_IRQ_O, 0, "interrupt not cleared");
  endtask : finish
  initial begin
    logic [23:0] r;
    int k;
    {ACT_I, EF_I, FW_I, FW_SEL_ADR_I, LOCKOUT_I, IRQ_TAKE_I} = 6'h00;
    {ACT_CHAN_I, FW_CHAN_I, EF_DEV_I, FW_DATA_I} = '0;
    {MEM_ACK_I, MEM_RDATA_I, stall, slow, dly} = '0;
    r = $urandom(51);
    repeat (4) @(posedge CLK_I);
    chk({ACTIVE_O, HOLD_O, MON_IRQ_O, MEM_O.req, OUT_VALID_O}, 0, "reset state");
    RESETN_I <= 1'b1;
    r = $urandom;
    pulse(1, 0, r);
    @(posedge CLK_I);
    chk(DEV_ADDR_O, r[5:0], "device select");
    for (int c = 0; c < 8; c++) begin
      stall <= {1'b0, c > 3};
      setup(c, 2);
      xfer(c, 0, 1);
      LOCKOUT_I <= c == 2;
      xfer(c, 1, 1);
      finish(c, 2, c == 2);
    end
    // two channels asking in the same cycle: both served, lower first
    setup(1, 1);
    setup(3, 1);
    fork
      xfer(3, 0, 0);
      xfer(1, 0, 0);
    join
    chk(HOLD_O, 0, "program still held");
    finish(1, 1, 0);
    finish(3, 1, 0);
    // receiver stalled: buffer fills, third word waits, then all drain in order
    setup(6, 3);
    stall <= 2'h2;
    for (int j = 0; j < 3; j++) P.pulse_out(2);
    repeat (20) @(posedge CLK_I);
    chk(ACTIVE_O[6], 1, "third word moved early");
    stall <= 2'h0;
    last = ~exp_d[6][0];
    for (int j = 0; j < 3; j++) begin
      k = 0;
      while (OUT_VALID_O !== 1'b1 || OUT_WORD_O.data === last) guard(k);
      last = OUT_WORD_O.data;
      chk(OUT_WORD_O, {2'h2, exp_d[6][j]}, "buffered word");
    end
    finish(6, 3, 0);
    end_of_test();
  end
endmodule : tb_buffered_io_channel_control
